/* File: common/csr_pkg.sv */
// constants shared by the chiller status register readout block
// assumes a host-side message layer hands in decoded read requests and takes word answers
// Function
// - the discharge pressure register returns the reading in the pressure unit selected now, megapascal or psi.
// - the resistivity/conductivity register returns zero whenever the optional sensor is not valid.
// - status word one bit 0 is 1 while the unit runs, pump-only running included, and 0 when stopped.
// - status word one bit 1 is 1 when an alarm that stops operation is raised.
// - status word one bit 2 is 1 when an alarm that lets operation go on is raised.
// - status word one bit 4 shows the pressure unit, 0 for megapascal and 1 for psi.
// - status word one bit 5 is 1 in serial remote-control mode and 0 in every other mode.
// - status word one bit 9 is 1 once the temperature-ready condition is met.
// - status word one bit 10 shows the temperature unit, 0 for Celsius and 1 for Fahrenheit.
// - status word one bits 11 and 12 show whether the run timer and the stop timer are set.
// - status word one bits 13 and 14 show whether restart after power loss and anti-freezing are on.
// - status word one bit 15 is 1 while automatic filling runs, and may move even without that option.
// - status word two bits 1 to 0 code the resistivity setting: 0 none, 1 resistivity, 2 conductivity.
// - a read naming an address outside the map gets an exception answer with error code 02.
package csr_pkg;

  localparam int unsigned WORD_W   = 16;
  localparam int unsigned ADDR_W   = 16;
  localparam int unsigned CODE_W   = 8;
  localparam int unsigned MAP_WORDS = 16;

  // register addresses
  localparam logic [15:0] ADDR_PRESSURE = 16'h0002;
  localparam logic [15:0] ADDR_COND     = 16'h0003;
  localparam logic [15:0] ADDR_STATUS1  = 16'h0004;
  localparam logic [15:0] ADDR_STATUS2  = 16'h0009;
  localparam logic [16:0] ADDR_LIMIT    = 17'h00010;

  // status word one fields
  localparam int unsigned S1_RUN        = 0;
  localparam int unsigned S1_STOP_ALARM = 1;
  localparam int unsigned S1_CONT_ALARM = 2;
  localparam int unsigned S1_PRESS_UNIT = 4;
  localparam int unsigned S1_REMOTE     = 5;
  localparam int unsigned S1_TEMP_READY = 9;
  localparam int unsigned S1_TEMP_UNIT  = 10;
  localparam int unsigned S1_RUN_TIMER  = 11;
  localparam int unsigned S1_STOP_TIMER = 12;
  localparam int unsigned S1_RESTART    = 13;
  localparam int unsigned S1_ANTIFREEZE = 14;
  localparam int unsigned S1_AUTOFILL   = 15;

  // status word two field
  localparam int unsigned S2_COND_LSB   = 0;
  localparam int unsigned S2_COND_W     = 2;

  localparam logic [1:0] COND_NOT_SET    = 2'h0;
  localparam logic [1:0] COND_RESISTIVITY = 2'h1;
  localparam logic [1:0] COND_CONDUCTIVITY = 2'h2;

  // exception codes
  localparam logic [7:0] ERR_FUNCTION = 8'h01;
  localparam logic [7:0] ERR_ADDRESS  = 8'h02;
  localparam logic [7:0] ERR_DATA     = 8'h03;

  // reset values and the single-word count
  localparam logic [15:0] WORD_ZERO   = 16'h0000;
  localparam logic [15:0] COUNT_ONE   = 16'h0001;
  localparam logic [7:0]  CODE_NONE   = 8'h00;

  // synchroniser depth for pin inputs
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    CSR_ST_IDLE   = 2'b00,
    CSR_ST_STREAM = 2'b01
  } csr_state_type;

endpackage

/* File: rtl/csr_sync.sv */
// multi-bit two-flop synchroniser for slow pin levels
// assumes each bit is an independent level held far longer than a clock period
`timescale 1ns/1ps
`default_nettype none
module csr_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_out
);

  if (WIDTH < 1) begin : g_chk
    $error("csr_sync: WIDTH must be at least 1");
  end

  // first stage is read only by the second stage
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_ff;
    logic hold_ff;
    always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
        meta_ff <= 1'b0;
        hold_ff <= 1'b0;
      end else begin
        meta_ff <= pin_in[i];
        hold_ff <= meta_ff;
      end
    end
    assign sync_out[i] = hold_ff;
  end

endmodule // csr_sync
`default_nettype wire

/* File: rtl/csr_word_pack.sv */
// assembles the readable words from synchronised unit state
// assumes all inputs are already in the sys_clk domain
`timescale 1ns/1ps
`default_nettype none
module csr_word_pack (
  input  wire logic        run,
  input  wire logic        stop_alarm,
  input  wire logic        cont_alarm,
  input  wire logic        press_psi,
  input  wire logic        serial_remote,
  input  wire logic        temp_ready,
  input  wire logic        temp_fahr,
  input  wire logic        run_timer_set,
  input  wire logic        stop_timer_set,
  input  wire logic        restart_on,
  input  wire logic        antifreeze_on,
  input  wire logic        autofill_active,
  input  wire logic [1:0]  cond_mode,
  input  wire logic        cond_valid,
  input  wire logic [15:0] press_mpa_val,
  input  wire logic [15:0] press_psi_val,
  input  wire logic [15:0] cond_val,
  output logic      [15:0] press_word,
  output logic      [15:0] cond_word,
  output logic      [15:0] status_one,
  output logic      [15:0] status_two
);

  // pressure follows the unit flag so value and flag always agree
  assign press_word = press_psi ? press_psi_val : press_mpa_val;
  assign cond_word  = cond_valid ? cond_val : csr_pkg::WORD_ZERO;

  // unlisted bits are tied low, so nothing can ever set them
  always_comb begin
    status_one = csr_pkg::WORD_ZERO;
    status_one[csr_pkg::S1_RUN]        = run;
    status_one[csr_pkg::S1_STOP_ALARM] = stop_alarm;
    status_one[csr_pkg::S1_CONT_ALARM] = cont_alarm;
    status_one[csr_pkg::S1_PRESS_UNIT] = press_psi;
    status_one[csr_pkg::S1_REMOTE]     = serial_remote;
    status_one[csr_pkg::S1_TEMP_READY] = temp_ready;
    status_one[csr_pkg::S1_TEMP_UNIT]  = temp_fahr;
    status_one[csr_pkg::S1_RUN_TIMER]  = run_timer_set;
    status_one[csr_pkg::S1_STOP_TIMER] = stop_timer_set;
    status_one[csr_pkg::S1_RESTART]    = restart_on;
    status_one[csr_pkg::S1_ANTIFREEZE] = antifreeze_on;
    status_one[csr_pkg::S1_AUTOFILL]   = autofill_active;
  end

  // code 3 is not defined, so it is shown as not set
  always_comb begin
    status_two = csr_pkg::WORD_ZERO;
    status_two[csr_pkg::S2_COND_LSB +: csr_pkg::S2_COND_W] =
      (cond_mode == 2'h3) ? csr_pkg::COND_NOT_SET : cond_mode;
  end

endmodule // csr_word_pack
`default_nettype wire

/* File: rtl/csr_readout.sv */
// register readout engine: takes decoded read requests, streams words or an exception
// assumes the message layer parses frames and adds the check code; unit state arrives on pins
`timescale 1ns/1ps
`default_nettype none
module csr_readout (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // decoded request from the message layer
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_count,
  // unit state pins
  input  wire logic        run_in,
  input  wire logic        stop_alarm_in,
  input  wire logic        cont_alarm_in,
  input  wire logic        press_psi_in,
  input  wire logic        serial_remote_in,
  input  wire logic        temp_ready_in,
  input  wire logic        temp_fahr_in,
  input  wire logic        run_timer_in,
  input  wire logic        stop_timer_in,
  input  wire logic        restart_in,
  input  wire logic        antifreeze_in,
  input  wire logic        autofill_in,
  input  wire logic [1:0]  cond_mode_in,
  input  wire logic        cond_valid_in,
  input  wire logic [15:0] press_mpa_in,
  input  wire logic [15:0] press_psi_value_in,
  input  wire logic [15:0] cond_value_in,
  // answer towards the message layer
  output logic             req_ready,
  output logic             rsp_valid,
  output logic             rsp_last,
  output logic             rsp_error,
  output logic      [7:0]  rsp_code,
  output logic      [15:0] rsp_data
);

  localparam int unsigned SYNC_W = 15 + 3 * csr_pkg::WORD_W;

  // ------------------------------------------------------------------
  // pin synchronisation
  // measurement words cross bit by bit; a word caught mid-change may
  // mix old and new bits for one sample, acceptable for slow readings
  // ------------------------------------------------------------------
  logic [SYNC_W-1:0] pin_bus;
  logic [SYNC_W-1:0] sync_bus;

  assign pin_bus = {cond_value_in, press_psi_value_in, press_mpa_in,
                    cond_valid_in, cond_mode_in, autofill_in, antifreeze_in,
                    restart_in, stop_timer_in, run_timer_in, temp_fahr_in,
                    temp_ready_in, serial_remote_in, press_psi_in,
                    cont_alarm_in, stop_alarm_in, run_in};

  csr_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .pin_in   (pin_bus),
    .sync_out (sync_bus)
  );

  // ------------------------------------------------------------------
  // word assembly
  // ------------------------------------------------------------------
  logic [15:0] press_word;
  logic [15:0] cond_word;
  logic [15:0] status_one;
  logic [15:0] status_two;

  csr_word_pack u_pack (
    .run             (sync_bus[0]),
    .stop_alarm      (sync_bus[1]),
    .cont_alarm      (sync_bus[2]),
    .press_psi       (sync_bus[3]),
    .serial_remote   (sync_bus[4]),
    .temp_ready      (sync_bus[5]),
    .temp_fahr       (sync_bus[6]),
    .run_timer_set   (sync_bus[7]),
    .stop_timer_set  (sync_bus[8]),
    .restart_on      (sync_bus[9]),
    .antifreeze_on   (sync_bus[10]),
    .autofill_active (sync_bus[11]),
    .cond_mode       (sync_bus[13:12]),
    .cond_valid      (sync_bus[14]),
    .press_mpa_val   (sync_bus[30:15]),
    .press_psi_val   (sync_bus[46:31]),
    .cond_val        (sync_bus[62:47]),
    .press_word      (press_word),
    .cond_word       (cond_word),
    .status_one      (status_one),
    .status_two      (status_two)
  );

  // ------------------------------------------------------------------
  // address decode
  // words of the map not owned here (temperatures, alarms, reserved)
  // read zero from this block; the message layer may overlay them
  // ------------------------------------------------------------------
  function automatic logic [15:0] word_at(
    input logic [15:0] addr,
    input logic [15:0] pw,
    input logic [15:0] cw,
    input logic [15:0] s1,
    input logic [15:0] s2
  );
    case (addr)
      csr_pkg::ADDR_PRESSURE: word_at = pw;
      csr_pkg::ADDR_COND:     word_at = cw;
      csr_pkg::ADDR_STATUS1:  word_at = s1;
      csr_pkg::ADDR_STATUS2:  word_at = s2;
      default:                word_at = csr_pkg::WORD_ZERO;
    endcase
  endfunction

  // true when the word span starting at addr stays inside the map
  function automatic logic span_in_map(
    input logic [15:0] addr,
    input logic [15:0] count
  );
    logic [16:0] last;
    last = {1'b0, addr} + {1'b0, count} - 17'h00001;
    span_in_map = ({1'b0, addr} < csr_pkg::ADDR_LIMIT) && (last < csr_pkg::ADDR_LIMIT);
  endfunction

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  csr_pkg::csr_state_type state_ff;
  csr_pkg::csr_state_type nxt_state;
  logic [15:0] addr_ff;
  logic [15:0] nxt_addr;
  logic [15:0] remain_ff;
  logic [15:0] nxt_remain;
  logic        ready_ff;
  logic        nxt_ready;
  logic        valid_ff;
  logic        nxt_valid;
  logic        last_ff;
  logic        nxt_last;
  logic        error_ff;
  logic        nxt_error;
  logic [7:0]  code_ff;
  logic [7:0]  nxt_code;
  logic [15:0] data_ff;
  logic [15:0] nxt_data;

  // ------------------------------------------------------------------
  // request checks, in the order the host protocol ranks them
  // ------------------------------------------------------------------
  wire         take       = req_valid && ready_ff && (state_ff == csr_pkg::CSR_ST_IDLE);
  wire         count_bad  = (req_count == csr_pkg::WORD_ZERO) ||
                            (req_count > 16'(csr_pkg::MAP_WORDS));
  wire         range_bad  = !span_in_map(req_addr, req_count);
  // every word here is read-only, so a write is refused as a whole
  wire         write_bad  = req_write;
  wire         reject     = write_bad || count_bad || range_bad;
  wire [7:0]   reject_code = write_bad ? csr_pkg::ERR_FUNCTION :
                             count_bad ? csr_pkg::ERR_DATA :
                                         csr_pkg::ERR_ADDRESS;
  wire         single     = (req_count == csr_pkg::COUNT_ONE);
  wire [15:0]  first_word = word_at(req_addr, press_word, cond_word, status_one, status_two);
  wire [15:0]  next_word  = word_at(addr_ff, press_word, cond_word, status_one, status_two);
  wire         stream_end = (remain_ff == csr_pkg::COUNT_ONE);

  // ------------------------------------------------------------------
  // next-state decode
  // ------------------------------------------------------------------
  always_comb begin
    nxt_state  = state_ff;
    nxt_addr   = addr_ff;
    nxt_remain = remain_ff;
    nxt_ready  = ready_ff;
    nxt_valid  = 1'b0;
    nxt_last   = 1'b0;
    nxt_error  = 1'b0;
    nxt_code   = csr_pkg::CODE_NONE;
    nxt_data   = csr_pkg::WORD_ZERO;
    case (state_ff)
      csr_pkg::CSR_ST_IDLE: begin
        if (take) begin
          nxt_valid = 1'b1;
          if (reject) begin
            // one exception beat carries the code instead of data
            nxt_last  = 1'b1;
            nxt_error = 1'b1;
            nxt_code  = reject_code;
          end else begin
            nxt_data = first_word;
            nxt_last = single;
            if (!single) begin
              nxt_state  = csr_pkg::CSR_ST_STREAM;
              nxt_addr   = req_addr + 16'h0001;
              nxt_remain = req_count - 16'h0001;
              nxt_ready  = 1'b0;
            end
          end
        end
      end
      csr_pkg::CSR_ST_STREAM: begin
        // one word per cycle, no stall: the message layer must keep up
        nxt_valid  = 1'b1;
        nxt_data   = next_word;
        nxt_addr   = addr_ff + 16'h0001;
        nxt_remain = remain_ff - 16'h0001;
        if (stream_end) begin
          nxt_last  = 1'b1;
          nxt_state = csr_pkg::CSR_ST_IDLE;
          nxt_ready = 1'b1;
        end
      end
      default: begin
        nxt_state = csr_pkg::CSR_ST_IDLE;
        nxt_ready = 1'b1;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_ff  <= csr_pkg::CSR_ST_IDLE;
      addr_ff   <= csr_pkg::WORD_ZERO;
      remain_ff <= csr_pkg::WORD_ZERO;
      ready_ff  <= 1'b1;
    end else begin
      state_ff  <= nxt_state;
      addr_ff   <= nxt_addr;
      remain_ff <= nxt_remain;
      ready_ff  <= nxt_ready;
    end
  end

  // answer registers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      valid_ff <= 1'b0;
      last_ff  <= 1'b0;
      error_ff <= 1'b0;
      code_ff  <= csr_pkg::CODE_NONE;
      data_ff  <= csr_pkg::WORD_ZERO;
    end else begin
      valid_ff <= nxt_valid;
      last_ff  <= nxt_last;
      error_ff <= nxt_error;
      code_ff  <= nxt_code;
      data_ff  <= nxt_data;
    end
  end

  // outputs straight from flip-flops
  assign req_ready = ready_ff;
  assign rsp_valid = valid_ff;
  assign rsp_last  = last_ff;
  assign rsp_error = error_ff;
  assign rsp_code  = code_ff;
  assign rsp_data  = data_ff;

endmodule // csr_readout
`default_nettype wire

/* File: dv/csr_readout_checker.sv */
// port-level checker for the status readout engine
// assumes pins are held for several cycles before a word that shows them is read
`timescale 1ns/1ps
`default_nettype none
module csr_readout_checker (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_count,
  input wire logic        run_in,
  input wire logic        stop_alarm_in,
  input wire logic        cont_alarm_in,
  input wire logic        press_psi_in,
  input wire logic        serial_remote_in,
  input wire logic        temp_ready_in,
  input wire logic        temp_fahr_in,
  input wire logic        run_timer_in,
  input wire logic        stop_timer_in,
  input wire logic        restart_in,
  input wire logic        antifreeze_in,
  input wire logic        autofill_in,
  input wire logic [1:0]  cond_mode_in,
  input wire logic        cond_valid_in,
  input wire logic [15:0] press_mpa_in,
  input wire logic [15:0] press_psi_value_in,
  input wire logic [15:0] cond_value_in,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic        rsp_last,
  input wire logic        rsp_error,
  input wire logic [7:0]  rsp_code,
  input wire logic [15:0] rsp_data
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [15:0] beat_addr_ff;
  logic [15:0] left_ff;
  logic [62:0] pins_ff;
  logic [3:0]  stab_ff;
  // request classification; 17-bit end avoids wrap on high head addresses
  wire logic [16:0] end_w    = {1'b0, req_addr} + {1'b0, req_count};
  wire logic        cnt_ok_w = (req_count != 16'h0000) && (req_count <= 16'h0010);
  wire logic        go_w     = req_valid && req_ready && !req_write && cnt_ok_w;
  wire logic        take_w   = go_w && (end_w <= 17'h00010);
  wire logic        bad_w    = go_w && (end_w > 17'h00010);
  wire logic [62:0] pins_w   = {run_in, stop_alarm_in, cont_alarm_in, press_psi_in, serial_remote_in,
                                temp_ready_in, temp_fahr_in, run_timer_in, stop_timer_in, restart_in,
                                antifreeze_in, autofill_in, cond_mode_in, cond_valid_in,
                                press_mpa_in, press_psi_value_in, cond_value_in};
  // data beats are judged only once pins are settled past the synchroniser
  wire logic        ok_w     = rsp_valid && !rsp_error && (stab_ff == 4'h8);
  wire logic [15:0] s1_w     = {autofill_in, antifreeze_in, restart_in, stop_timer_in, run_timer_in,
                                temp_fahr_in, temp_ready_in, 3'h0, serial_remote_in, press_psi_in,
                                1'b0, cont_alarm_in, stop_alarm_in, run_in};
  // beat address tracking and pin stability counter
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      beat_addr_ff <= 16'h0000;
      left_ff      <= 16'h0000;
      pins_ff      <= '0;
      stab_ff      <= 4'h0;
    end else begin
      pins_ff <= pins_w;
      stab_ff <= (pins_w != pins_ff) ? 4'h0 : ((stab_ff == 4'h8) ? stab_ff : stab_ff + 4'h1);
      if (take_w) begin
        beat_addr_ff <= req_addr;
        left_ff      <= req_count;
      end else if (rsp_valid && !rsp_error && left_ff != 16'h0000) begin
        beat_addr_ff <= beat_addr_ff + 16'h0001;
        left_ff      <= left_ff - 16'h0001;
      end
    end
  end
  property p_press;
    ok_w && beat_addr_ff == csr_pkg::ADDR_PRESSURE |-> rsp_data == (press_psi_in ? press_psi_value_in : press_mpa_in);
  endproperty
  a_press: assert property (p_press) else $error("pressure word wrong");
  property p_cond;
    ok_w && beat_addr_ff == csr_pkg::ADDR_COND && !cond_valid_in |-> rsp_data == 16'h0000;
  endproperty
  a_cond: assert property (p_cond) else $error("invalid sensor word not zero");
  property p_s1_low;
    ok_w && beat_addr_ff == csr_pkg::ADDR_STATUS1 |-> rsp_data[2:0] == s1_w[2:0];
  endproperty
  a_s1_low: assert property (p_s1_low) else $error("run or alarm flags wrong");
  property p_s1_mid;
    ok_w && beat_addr_ff == csr_pkg::ADDR_STATUS1 |-> rsp_data[5:4] == s1_w[5:4];
  endproperty
  a_s1_mid: assert property (p_s1_mid) else $error("unit or remote flag wrong");
  property p_s1_high;
    ok_w && beat_addr_ff == csr_pkg::ADDR_STATUS1 |-> rsp_data[15:9] == s1_w[15:9];
  endproperty
  a_s1_high: assert property (p_s1_high) else $error("upper status flags wrong");
  property p_unused;
    ok_w && beat_addr_ff == csr_pkg::ADDR_STATUS1 |-> {rsp_data[8:6], rsp_data[3]} == 4'h0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused status bit set");
  property p_s2;
    ok_w && beat_addr_ff == csr_pkg::ADDR_STATUS2 |-> rsp_data == {14'h0, (&cond_mode_in) ? 2'h0 : cond_mode_in};
  endproperty
  a_s2: assert property (p_s2) else $error("status two wrong");
  property p_err;
    bad_w |=> rsp_valid && rsp_error && rsp_last && rsp_code == csr_pkg::ERR_ADDRESS;
  endproperty
  a_err: assert property (p_err) else $error("out of map read not refused");
  property p_last;
    rsp_valid && !rsp_error |-> rsp_last == (left_ff == 16'h0001);
  endproperty
  a_last: assert property (p_last) else $error("last beat misplaced");
  property p_busy;
    take_w && req_count > 16'h0001 |=> !req_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready during multi-word read");
  property p_quiet;
    !rsp_valid |-> rsp_data == 16'h0000 && rsp_code == 8'h00;
  endproperty
  a_quiet: assert property (p_quiet) else $error("answer lines not quiet");
  c_full: cover property (take_w && req_count == 16'h0010);
  c_bad: cover property (bad_w);
  c_s2: cover property (ok_w && beat_addr_ff == csr_pkg::ADDR_STATUS2);
endmodule // csr_readout_checker
`default_nettype wire

/* File: dv/csr_host_model.sv */
// remote host model: issues decoded read or write requests and gathers the answer beats
// assumes it is the only master of the request port; drives on falling edges
`timescale 1ns/1ps
`default_nettype none
module csr_host_model (
  input  wire logic        sys_clk,
  input  wire logic        req_ready,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_last,
  input  wire logic        rsp_error,
  input  wire logic [7:0]  rsp_code,
  input  wire logic [15:0] rsp_data,
  output var  logic        req_valid,
  output var  logic        req_write,
  output var  logic [15:0] req_addr,
  output var  logic [15:0] req_count
);
  logic [15:0] rx_data [16];
  logic        rx_err;
  logic [7:0]  rx_code;
  int          rx_n;
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr  = 16'h0000;
    req_count = 16'h0000;
  end
  // a new request waits for the last beat, so multi-word reads never overlap
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] n);
    int   k   = 0;
    logic fin = 1'b0;
    rx_n = 0;
    rx_err = 1'b0;
    @(negedge sys_clk);
    req_valid = 1'b1;
    req_write = wr;
    req_addr  = a;
    req_count = n;
    @(posedge sys_clk);
    while (req_ready !== 1'b1) @(posedge sys_clk);
    @(negedge sys_clk);
    req_valid = 1'b0;
    while (!fin && k < 40) begin
      if (rsp_valid === 1'b1) begin
        if (rx_n < 16) rx_data[rx_n] = rsp_data;
        rx_n++;
        rx_err  = rsp_error;
        rx_code = rsp_code;
        fin     = (rsp_last === 1'b1);
      end
      k++;
      if (!fin) @(negedge sys_clk);
    end
  endtask
endmodule // csr_host_model
`default_nettype wire

/* File: dv/csr_readout_tb_top.sv */
// self-checking bench for the status readout engine with a host request model
// assumes the readout answers within a few dozen cycles of each request
`timescale 1ns/1ps
`default_nettype none
module csr_readout_tb_top;
  logic        sys_clk, reset, valid;
  logic [11:0] flags;
  logic [1:0]  mode;
  logic [15:0] mpa, psv, cv, req_addr, req_count, rsp_data;
  logic        req_valid, req_write, req_ready, rsp_valid, rsp_last, rsp_error;
  logic [7:0]  rsp_code;
  int          error_cnt = 0;
  int          checks = 0;
  logic [15:0] ea [5] = '{16'h0004, 16'h0004, 16'h0004, 16'h0100, 16'h000f};
  logic [15:0] en [5] = '{16'h0001, 16'h0000, 16'h0011, 16'h0007, 16'h0002};
  logic [7:0]  ec [5] = '{8'h01, 8'h03, 8'h03, 8'h02, 8'h02};
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  csr_readout dut_u (.sys_clk(sys_clk), .reset(reset), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_count(req_count), .run_in(flags[0]), .stop_alarm_in(flags[1]),
    .cont_alarm_in(flags[2]), .press_psi_in(flags[3]), .serial_remote_in(flags[4]), .temp_ready_in(flags[5]),
    .temp_fahr_in(flags[6]), .run_timer_in(flags[7]), .stop_timer_in(flags[8]), .restart_in(flags[9]),
    .antifreeze_in(flags[10]), .autofill_in(flags[11]), .cond_mode_in(mode), .cond_valid_in(valid),
    .press_mpa_in(mpa), .press_psi_value_in(psv), .cond_value_in(cv), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_last(rsp_last), .rsp_error(rsp_error), .rsp_code(rsp_code), .rsp_data(rsp_data));
  csr_host_model host_u (.sys_clk(sys_clk), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_last(rsp_last),
    .rsp_error(rsp_error), .rsp_code(rsp_code), .rsp_data(rsp_data), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_count(req_count));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // expected word from the pin levels the bench drives
  function automatic logic [15:0] exp_word(input int a);
    case (a)
      2: return flags[3] ? psv : mpa;
      3: return valid ? cv : 16'h0000;
      4: return {flags[11:5], 3'h0, flags[4:3], 1'b0, flags[2:0]};
      9: return {14'h0, (mode == 2'h3) ? 2'h0 : mode};
      default: return 16'h0000;
    endcase
  endfunction
  // pins change, then settle well past the synchroniser before any read
  task automatic pins(input logic [11:0] f, input logic [1:0] m, input logic v, input logic [15:0] p0,
                      input logic [15:0] p1, input logic [15:0] c);
    @(negedge sys_clk);
    flags = f;
    mode  = m;
    valid = v;
    mpa   = p0;
    psv   = p1;
    cv    = c;
    repeat (10) @(negedge sys_clk);
  endtask
  task automatic full();
    host_u.xfer(1'b0, 16'h0000, 16'h0010);
    chk(16'(host_u.rx_n), 16'h0010);
    for (int i = 0; i < 16; i++) chk(host_u.rx_data[i], exp_word(i));
  endtask
  initial begin
    reset = 1'b1;
    flags = 12'h000;
    mode  = 2'h0;
    valid = 1'b0;
    {mpa, psv, cv} = 48'h0;
    repeat (8) @(posedge sys_clk);
    chk({15'h0, req_ready}, 16'h0001);
    chk({15'h0, rsp_valid}, 16'h0000);
    @(negedge sys_clk);
    reset = 1'b0;
    pins(12'ha5a, 2'h1, 1'b1, 16'h012c, 16'h01b3, 16'h002d);
    full();
    pins(12'h5a5, 2'h2, 1'b0, 16'h0123, 16'h01a0, 16'h0014);
    full();
    pins(12'hfff, 2'h3, 1'b1, 16'h0000, 16'h0001, 16'h01e0);
    full();
    // every setting code of status word two, including the undefined one
    for (int m = 0; m < 4; m++) begin
      pins(flags, 2'(m), valid, mpa, psv, cv);
      host_u.xfer(1'b0, csr_pkg::ADDR_STATUS2, 16'h0001);
      chk(host_u.rx_data[0], exp_word(9));
    end
    // refused requests: write, bad counts, out of map heads and tails
    for (int i = 0; i < 5; i++) begin
      host_u.xfer(i == 0, ea[i], en[i]);
      chk(16'(host_u.rx_n), 16'h0001);
      chk({15'h0, host_u.rx_err}, 16'h0001);
      chk({8'h0, host_u.rx_code}, {8'h0, ec[i]});
    end
    host_u.xfer(1'b0, csr_pkg::ADDR_STATUS1, 16'h0001);
    chk(host_u.rx_data[0], exp_word(4));
    host_u.xfer(1'b0, 16'h000e, 16'h0002);
    chk(16'(host_u.rx_n), 16'h0002);
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    end_of_test();
  end
endmodule // csr_readout_tb_top
bind csr_readout csr_readout_checker chk_u (.sys_clk(sys_clk), .reset(reset), .req_valid(req_valid),
  .req_write(req_write), .req_addr(req_addr), .req_count(req_count), .run_in(run_in),
  .stop_alarm_in(stop_alarm_in), .cont_alarm_in(cont_alarm_in), .press_psi_in(press_psi_in),
  .serial_remote_in(serial_remote_in), .temp_ready_in(temp_ready_in), .temp_fahr_in(temp_fahr_in),
  .run_timer_in(run_timer_in), .stop_timer_in(stop_timer_in), .restart_in(restart_in),
  .antifreeze_in(antifreeze_in), .autofill_in(autofill_in), .cond_mode_in(cond_mode_in),
  .cond_valid_in(cond_valid_in), .press_mpa_in(press_mpa_in), .press_psi_value_in(press_psi_value_in),
  .cond_value_in(cond_value_in), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_last(rsp_last),
  .rsp_error(rsp_error), .rsp_code(rsp_code), .rsp_data(rsp_data));
`default_nettype wire
